// ### hdl/qupcr_pkg.sv
// shared constants and carrier types of the quad uart pin, clock and reset block
package qupcr_pkg;
  localparam int NCH    = 4;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // ***********************************************
  // register map (address = channel * 4 + register)
  // ***********************************************
  localparam logic [1:0]        REG_MCR     = 2'h0;
  localparam logic [1:0]        REG_FEATURE_CONTROL_REG    = 2'h1;
  localparam logic [1:0]        REG_DIV     = 2'h2;
  localparam logic [1:0]        REG_MSR     = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL = 5'h10;
  localparam int                ADDR_CHAN_BIT = 4;

  localparam int MCR_TERM   = 0;
  localparam int MCR_OP1    = 2;
  localparam int MCR_OP2    = 3;
  localparam int MCR_DIV4   = 7;
  localparam int FEATURE_CONTROL_REG_RS485 = 3;
  localparam int MSR_DSR    = 5;
  localparam int MSR_RI     = 6;
  localparam int MSR_CD     = 7;
  localparam int GLB_INTEL  = 0;
  localparam int GLB_STRAP  = 1;
  localparam int GLB_RST    = 2;

  localparam logic [7:0]  MCR_RST  = 8'h00;
  localparam logic [7:0]  FEATURE_CONTROL_REG_RST = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  localparam logic [1:0]  PRE_MAX  = 2'h3;
  localparam int          CHAN_C   = 2;

  // ***********************************************
  // pin sampling vector layout
  // ***********************************************
  localparam int P_DSR   = 0;
  localparam int P_CD    = 4;
  localparam int P_RI    = 8;
  localparam int P_RX    = 12;
  localparam int P_RST   = 16;
  localparam int P_BUS   = 17;
  localparam int P_STRAP = 18;
  localparam int P_OSC   = 19;
  localparam int P_CHC   = 20;
  localparam int NPIN    = 21;
  // idle levels: modem lines high, rx high, reset pin low, bus strap high
  localparam logic [NPIN-1:0] PIN_IDLE = 21'h02FFFF;

  // ***********************************************
  // timing
  // ***********************************************
  localparam int CLK_NS     = 10;
  localparam int RST_MIN_NS = 40;
  localparam int RST_CYC_I  = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] RST_CYC   = 3'(RST_CYC_I);
  localparam logic [2:0] BOOT_DONE = 3'h4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } qupcr_bus_req_t;

  typedef struct packed {
    logic [NCH-1:0] set_ready_in_n;
    logic [NCH-1:0] carrier_detect_in_n;
    logic [NCH-1:0] ring_detect_in_n;
    logic [NCH-1:0] rx;
  } qupcr_line_in_t;

  typedef struct packed {
    logic [NCH-1:0] term_ready_out_n;
    logic [NCH-1:0] gp_out_first_n;
    logic [NCH-1:0] gp_out_second_n;
    logic [NCH-1:0] baud_clk_out;
    logic [NCH-1:0] tx;
  } qupcr_line_out_t;
endpackage : qupcr_pkg

// ### hdl/qupcr_top.sv
// pin-level modem lines, baud clocks, straps and reset of a four channel uart
//
// What this block does
// - each channel drives its own active-low terminal-ready output from software.
// - set-ready, carrier-detect and ring inputs per channel are readable by software.
// - first general output becomes rs-485 direction when feature control bit 3 set.
// - second general output is a plain software-controlled output.
// - baud clock pin carries the 16x clock, also used as receive clock.
// - bus select strap high selects intel style, low selects motorola style.
// - prescaler strap sampled only during reset; later changes ignored.
// - strap high feeds baud generator clock divided by 1, low by 4.
// - after reset, modem control bit 7 overrides the latched prescaler choice.
// - channel c is clocked from its dedicated clock input.
// - intel style: reset pin active high resets registers and outputs.
// - motorola style: reset pin active low gives the same full reset.
// - during reset transmit outputs stay high and receive inputs are ignored.
// - oscillator output pin carries a buffered copy of the oscillator input.
`timescale 1ns/100ps
module qupcr_top
  import qupcr_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire qupcr_pkg::qupcr_bus_req_t bus,
  output logic [qupcr_pkg::DATA_W-1:0]   rdata,
  input  wire qupcr_pkg::qupcr_line_in_t line_in,
  output qupcr_pkg::qupcr_line_out_t     line_out,
  input  wire logic                      reset_pin,
  input  wire logic                      bus_select_strap,
  input  wire logic                      prescaler_strap,
  input  wire logic                      osc_in,
  output logic                           osc_out,
  input  wire logic                      chan_c_clk_in,
  input  wire logic [qupcr_pkg::NCH-1:0] tx_core,
  input  wire logic [qupcr_pkg::NCH-1:0] tx_busy,
  output logic [qupcr_pkg::NCH-1:0]      rx_core,
  output logic [qupcr_pkg::NCH-1:0]      rx_tick,
  output logic                           intel_mode,
  output logic                           int_reset
);
  import qupcr_pkg::*;

  typedef struct packed {
    logic [NPIN-1:0]       s1;
    logic [NPIN-1:0]       s2;
    logic [NPIN-1:0]       s3;
    logic [NPIN-1:0]       flt;
    logic [1:0]            edg_prev;
    logic [2:0]            rcnt;
    logic [2:0]            boot;
    logic                  strap;
    logic [NCH-1:0][7:0]   modem_control_reg;
    logic [NCH-1:0][7:0]   feature_control_reg;
    logic [NCH-1:0][15:0]  div;
    logic [NCH-1:0][15:0]  cnt;
    logic [NCH-1:0][1:0]   pre;
    logic [NCH-1:0]        rtick;
    logic [NCH-1:0]        bclk;
    logic [NCH-1:0]        term_n;
    logic [NCH-1:0]        op1_n;
    logic [NCH-1:0]        op2_n;
    logic [NCH-1:0]        tx;
    logic [NCH-1:0]        rx;
    logic                  osc_o;
    logic [DATA_W-1:0]     rdata;
  } qupcr_state_t;

  qupcr_state_t    q;
  qupcr_state_t    n;
  logic [NPIN-1:0] pins;
  logic [NCH-1:0]  dtr_v;
  logic [NCH-1:0]  op1_v;
  logic [NCH-1:0]  op2_v;
  logic [NCH-1:0]  rs485_v;
  logic [NCH-1:0]  div4_v;
  logic [NCH-1:0]  src_tick;
  logic [NCH-1:0]  pre_tick;
  logic            osc_edge;
  logic            chc_edge;
  logic            dev_rst;

  // ***********************************************
  // address decode helpers
  // ***********************************************
  function automatic logic is_chan(input logic [ADDR_W-1:0] a);
    return !a[ADDR_CHAN_BIT];
  endfunction : is_chan

  function automatic logic [1:0] chan_of(input logic [ADDR_W-1:0] a);
    return a[3:2];
  endfunction : chan_of

  assign pins = {chan_c_clk_in, osc_in, prescaler_strap, bus_select_strap, reset_pin,
                 line_in.rx, line_in.ring_detect_in_n, line_in.carrier_detect_in_n,
                 line_in.set_ready_in_n};

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_fields
      assign dtr_v[g]   = q.modem_control_reg[g][MCR_TERM];
      assign op1_v[g]   = q.modem_control_reg[g][MCR_OP1];
      assign op2_v[g]   = q.modem_control_reg[g][MCR_OP2];
      assign div4_v[g]  = q.modem_control_reg[g][MCR_DIV4];
      assign rs485_v[g] = q.feature_control_reg[g][FEATURE_CONTROL_REG_RS485];
      assign src_tick[g] = (g == CHAN_C) ? chc_edge : osc_edge;
      assign pre_tick[g] = src_tick[g] && (!div4_v[g] || q.pre[g] == PRE_MAX);
    end
  endgenerate

  assign osc_edge   = q.flt[P_OSC] && !q.edg_prev[0];
  assign chc_edge   = q.flt[P_CHC] && !q.edg_prev[1];
  assign dev_rst    = (q.rcnt == RST_CYC);
  // the boot hold lets the synchronisers settle so the strap is caught from the pin
  assign int_reset  = !rstn || dev_rst || (q.boot != BOOT_DONE);
  assign intel_mode = q.flt[P_BUS];

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    logic [16:0] half;
    logic [1:0]  ch;
    half = 17'h00000;
    ch   = chan_of(bus.addr);
    n    = q;
    n.s1 = pins;
    n.s2 = q.s1;
    n.s3 = q.s2;
    // a pin change counts only once the second and third stage agree
    for (int i = 0; i < NPIN; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.flt[i] = q.s3[i];
      end
    end
    n.edg_prev = {q.flt[P_CHC], q.flt[P_OSC]};
    n.osc_o    = q.flt[P_OSC];
    // reset pin is active when its level matches the bus select strap
    if (q.flt[P_RST] == q.flt[P_BUS]) begin
      n.rcnt = (q.rcnt == RST_CYC) ? q.rcnt : q.rcnt + 3'h1;
    end else begin
      n.rcnt = 3'h0;
    end
    if (q.boot != BOOT_DONE) begin
      n.boot = q.boot + 3'h1;
    end

    for (int c = 0; c < NCH; c++) begin
      n.rtick[c] = 1'b0;
      if (src_tick[c]) begin
        n.pre[c] = div4_v[c] ? q.pre[c] + 2'h1 : 2'h0;
      end
      if (pre_tick[c]) begin
        if (q.cnt[c] >= q.div[c] - 16'h0001) begin
          n.cnt[c]   = 16'h0000;
          n.rtick[c] = 1'b1;
        end else begin
          n.cnt[c] = q.cnt[c] + 16'h0001;
        end
      end
      half      = ({1'b0, q.div[c]} + 17'h00001) >> 1;
      n.bclk[c] = {1'b0, n.cnt[c]} < half;
      n.term_n[c] = !dtr_v[c];
      n.op1_n[c]  = rs485_v[c] ? !tx_busy[c] : !op1_v[c];
      n.op2_n[c]  = !op2_v[c];
      n.tx[c]     = tx_core[c];
      n.rx[c]     = q.flt[P_RX + c];
    end

    // software access; read data stand for one cycle only
    n.rdata = '0;
    if (bus.wr && is_chan(bus.addr)) begin
      unique case (bus.addr[1:0])
        REG_MCR:  n.modem_control_reg[ch]  = bus.wdata[7:0];
        REG_FEATURE_CONTROL_REG: n.feature_control_reg[ch] = bus.wdata[7:0];
        REG_DIV:  n.div[ch]  = bus.wdata;
        REG_MSR:  n.rdata    = '0;
      endcase
    end
    if (bus.rd) begin
      if (bus.addr == ADDR_GLOBAL) begin
        n.rdata[GLB_INTEL] = q.flt[P_BUS];
        n.rdata[GLB_STRAP] = q.strap;
        n.rdata[GLB_RST]   = dev_rst;
      end else if (is_chan(bus.addr)) begin
        unique case (bus.addr[1:0])
          REG_MCR:  n.rdata = {8'h00, q.modem_control_reg[ch]};
          REG_FEATURE_CONTROL_REG: n.rdata = {8'h00, q.feature_control_reg[ch]};
          REG_DIV:  n.rdata = q.div[ch];
          REG_MSR: begin
            n.rdata[MSR_DSR] = !q.flt[P_DSR + 32'(ch)];
            n.rdata[MSR_RI]  = !q.flt[P_RI + 32'(ch)];
            n.rdata[MSR_CD]  = !q.flt[P_CD + 32'(ch)];
          end
        endcase
      end
    end

    if (int_reset) begin
      // take the filter's next value: on the last boot edge only that one holds the pin
      n.strap = n.flt[P_STRAP];
      for (int c = 0; c < NCH; c++) begin
        n.modem_control_reg[c]           = MCR_RST;
        n.modem_control_reg[c][MCR_DIV4] = !n.flt[P_STRAP];
      end
      n.feature_control_reg   = {NCH{FEATURE_CONTROL_REG_RST}};
      n.div    = {NCH{DIV_RST}};
      n.cnt    = '0;
      n.pre    = '0;
      n.rtick  = '0;
      n.bclk   = '0;
      n.term_n = '1;
      n.op1_n  = '1;
      n.op2_n  = '1;
      n.tx     = '1;
      n.rx     = '1;
      // the global status stays readable so software can watch a pin reset
      if (!(bus.rd && bus.addr == ADDR_GLOBAL)) begin
        n.rdata = '0;
      end
    end
    if (!rstn) begin
      n.s1       = PIN_IDLE;
      n.s2       = PIN_IDLE;
      n.s3       = PIN_IDLE;
      n.flt      = PIN_IDLE;
      n.edg_prev = 2'h0;
      n.rcnt     = 3'h0;
      n.boot     = 3'h0;
      n.osc_o    = 1'b0;
      n.rdata    = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= n;
  end

  assign rdata                     = q.rdata;
  assign line_out.term_ready_out_n = q.term_n;
  assign line_out.gp_out_first_n   = q.op1_n;
  assign line_out.gp_out_second_n  = q.op2_n;
  assign line_out.baud_clk_out     = q.bclk;
  assign line_out.tx               = q.tx;
  assign rx_core                   = q.rx;
  assign rx_tick                   = q.rtick;
  assign osc_out                   = q.osc_o;

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_term;
    !int_reset |=> line_out.term_ready_out_n == ~$past(dtr_v);
  endproperty
  a_term: assert property (p_term) else $error("terminal ready not from control bit");

  property p_msr;
    bus.rd && bus.addr == {3'h0, REG_MSR} && !int_reset
      |=> rdata[MSR_DSR] == !$past(q.flt[P_DSR]) && rdata[MSR_CD] == !$past(q.flt[P_CD]);
  endproperty
  a_msr: assert property (p_msr) else $error("modem status read wrong");

  property p_rs485;
    !int_reset && rs485_v[0] && tx_busy[0] |=> !line_out.gp_out_first_n[0];
  endproperty
  a_rs485: assert property (p_rs485) else $error("direction output not driven");

  property p_op2;
    !int_reset ##1 !int_reset |-> line_out.gp_out_second_n == ~$past(op2_v);
  endproperty
  a_op2: assert property (p_op2) else $error("second output not software");

  property p_tick;
    rx_tick[0] |-> q.cnt[0] == 16'h0000 && $past(pre_tick[0]);
  endproperty
  a_tick: assert property (p_tick) else $error("receive tick without divider wrap");

  property p_chc;
    rx_tick[CHAN_C] |-> $past(chc_edge);
  endproperty
  a_chc: assert property (p_chc) else $error("channel c tick not from its clock");

  property p_strap;
    !int_reset |=> $stable(q.strap);
  endproperty
  a_strap: assert property (p_strap) else $error("strap changed outside reset");

  property p_div1;
    src_tick[0] && !div4_v[0] |-> pre_tick[0];
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one dropped a tick");

  property p_override;
    !int_reset && bus.wr && bus.addr == {3'h0, REG_MCR} |=> div4_v[0] == $past(bus.wdata[7]);
  endproperty
  a_override: assert property (p_override) else $error("prescaler override lost");

  property p_devrst;
    dev_rst |=> line_out.tx == '1 && line_out.term_ready_out_n == '1 && q.div[1] == DIV_RST;
  endproperty
  a_devrst: assert property (p_devrst) else $error("pin reset incomplete");

  property p_rx_ign;
    int_reset |=> rx_core == '1 && rx_tick == '0;
  endproperty
  a_rx_ign: assert property (p_rx_ign) else $error("receive not held during reset");

  property p_osc;
    ##1 osc_out == $past(q.flt[P_OSC]);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator copy wrong");

  c_chc_tick: cover property (rx_tick[CHAN_C]);
  c_rs485: cover property (rs485_v[0] && tx_busy[0] ##1 !line_out.gp_out_first_n[0]);
  c_devrst: cover property (dev_rst ##1 !dev_rst);
  c_div4: cover property (div4_v[1] && rx_tick[1]);
endmodule : qupcr_top

// ### verification/qupcr_modem.sv
// modem-side partner: loops the device's control outputs onto its status inputs
`timescale 1ns/100ps
module qupcr_modem
  import qupcr_pkg::*;
(
  input  wire qupcr_pkg::qupcr_line_out_t lo,
  input  wire logic                       rx_low,
  output qupcr_pkg::qupcr_line_in_t       li
);
  // ****************
  // null-modem wiring
  // ****************
  // looping lets the bench steer every status input through a control output
  assign li.set_ready_in_n      = lo.term_ready_out_n;
  assign li.carrier_detect_in_n = lo.gp_out_second_n;
  assign li.ring_detect_in_n    = lo.gp_out_first_n;
  // rx_low shows a live line during reset that the device must not pass on
  assign li.rx                  = lo.tx & ~{NCH{rx_low}};
endmodule : qupcr_modem

// ### verification/qupcr_top_tb.sv
// self-checking bench of the pin, clock and reset block
`timescale 1ns/100ps
module qupcr_top_tb;
  import qupcr_pkg::*;
  logic              clk  = 1'b0;
  logic              rstn = 1'b0;
  qupcr_bus_req_t    bus  = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] d;
  qupcr_line_in_t    li;
  qupcr_line_out_t   lo;
  logic              rst_pin = 1'b0;
  logic              bsel    = 1'b1;
  logic              pstrap  = 1'b1;
  logic              osc     = 1'b0;
  logic              chc     = 1'b0;
  logic              rxl     = 1'b0;
  logic              oso;
  logic              intel;
  logic              irst;
  logic [NCH-1:0]    txc = 4'hF;
  logic [NCH-1:0]    txb = 4'h0;
  logic [NCH-1:0]    rxc;
  logic [NCH-1:0]    tick;
  int                err_count = 0;
  int                checked   = 0;
  int                cyc = 0;
  int                t0  = 0;
  int                t2  = 0;
  int                no  = 0;
  int                nb  = 0;

  always #5 clk = ~clk;

  qupcr_top DUT (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .line_in(li),
    .line_out(lo), .reset_pin(rst_pin), .bus_select_strap(bsel),
    .prescaler_strap(pstrap), .osc_in(osc), .osc_out(oso), .chan_c_clk_in(chc),
    .tx_core(txc), .tx_busy(txb), .rx_core(rxc), .rx_tick(tick),
    .intel_mode(intel), .int_reset(irst));

  qupcr_modem MDM (.lo(lo), .rx_low(rxl), .li(li));

  // *****************************************
  // source clocks and edge counters
  // *****************************************
  // sources stay well below the sampler limit: 8 and 16 cycle periods
  always @(posedge clk) begin
    cyc <= cyc + 1;
    osc <= cyc[2];
    chc <= cyc[3];
    t0  <= t0 + int'(tick[0]);
    t2  <= t2 + int'(tick[2]);
    no  <= no + int'($rose(oso));
    nb  <= nb + int'($rose(lo.baud_clk_out[0]));
  end

  // *****************************************
  // access and compare tasks
  // *****************************************
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // settle past the edge before looking at outputs
  task ws(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : ws

  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask : rd

  task reset_n;
    @(posedge clk);
    rstn <= 1'b0;
    wt(2);
    rstn <= 1'b1;
    wt(8);
  endtask : reset_n

  task win(output int a0, output int a2, output int ao);
    int s0;
    int s2;
    int so;
    s0 = t0;
    s2 = t2;
    so = no;
    ws(160);
    a0 = t0 - s0;
    a2 = t2 - s2;
    ao = no - so;
  endtask : win

  task tdone(input string n);
    $display("test %s done", n);
  endtask : tdone

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    wt(20000);
    err_count++;
    tally_and_finish();
  end

  // *****************************************
  // test sequence
  // *****************************************
  initial begin
    int a0;
    int a2;
    int ao;
    int b0;
    reset_n();
    #1;
    chk("outs", 16'h0FFF, 16'({lo.term_ready_out_n, lo.gp_out_first_n, lo.gp_out_second_n}));
    rd(ADDR_GLOBAL);
    chk("glb", 16'h0003, 16'(d[2:0]));
    chk("intel", 16'h0001, 16'(intel));
    rd(5'h00);
    chk("mcr_div", 16'h0000, 16'(d[7:0]));
    tdone("reset");
    wr(5'h00, 16'h000D);
    ws(2);
    chk("ctl", 16'h0EEE, 16'({lo.term_ready_out_n, lo.gp_out_first_n, lo.gp_out_second_n}));
    wt(6);
    rd(5'h03);
    chk("msr_on", 16'h0007, 16'(d[7:5]));
    wr(5'h00, 16'h0000);
    wt(6);
    rd(5'h03);
    chk("msr_off", 16'h0000, 16'(d[7:5]));
    tdone("modem");
    wr(5'h05, 16'h0008);
    txb <= 4'h2;
    ws(2);
    chk("dir_on", 16'h000D, 16'(lo.gp_out_first_n));
    @(posedge clk);
    txb <= 4'h0;
    ws(2);
    chk("dir_off", 16'h000F, 16'(lo.gp_out_first_n));
    rd(5'h05);
    chk("feature_control_reg", 16'h0008, d);
    tdone("rs485");
    win(a0, a2, ao);
    chk("tick_a", 16'h0001, 16'(a0 inside {[19:21]}));
    chk("tick_c", 16'h0001, 16'(a2 inside {[9:11]}));
    chk("osc_out", 16'h0001, 16'(ao inside {[19:21]}));
    chk("bclk", 16'h0001, 16'(lo.baud_clk_out[0]));
    @(posedge clk);
    pstrap <= 1'b0;
    wt(4);
    rd(ADDR_GLOBAL);
    chk("strap_held", 16'h0001, 16'(d[1]));
    win(a0, a2, ao);
    chk("tick_held", 16'h0001, 16'(a0 inside {[19:21]}));
    reset_n();
    rd(5'h00);
    chk("mcr_div4", 16'h0080, 16'(d[7:0]));
    win(a0, a2, ao);
    chk("tick_div4", 16'h0001, 16'(a0 inside {[4:6]}));
    wr(5'h00, 16'h0000);
    win(a0, a2, ao);
    chk("tick_ovr", 16'h0001, 16'(a0 inside {[19:21]}));
    wr(5'h02, 16'h0004);
    rd(5'h02);
    chk("div", 16'h0004, d);
    b0 = nb;
    win(a0, a2, ao);
    chk("tick_div", 16'h0001, 16'(a0 inside {[4:6]}));
    chk("bclk_rise", 16'h0001, 16'((nb - b0) inside {[4:6]}));
    tdone("baud");
    wr(5'h00, 16'h000D);
    txc <= 4'h5;
    ws(8);
    chk("txrx_run", 16'h0055, 16'({lo.tx, rxc}));
    @(posedge clk);
    rst_pin <= 1'b1;
    txc     <= 4'h0;
    rxl     <= 1'b1;
    ws(10);
    chk("pin_rst_i", 16'h0001, 16'(irst));
    chk("outs_i", 16'h0FFF, 16'({lo.term_ready_out_n, lo.gp_out_first_n, lo.gp_out_second_n}));
    chk("txrx_rst", 16'h00FF, 16'({lo.tx, rxc}));
    rd(ADDR_GLOBAL);
    chk("glb_rst", 16'h0005, 16'(d[2:0]));
    @(posedge clk);
    rst_pin <= 1'b0;
    rxl     <= 1'b0;
    wt(12);
    rd(5'h00);
    chk("mcr_clr", 16'h0000, 16'(d[3:0]));
    tdone("intel_reset");
    @(posedge clk);
    rst_pin <= 1'b1;
    bsel    <= 1'b0;
    wt(12);
    rd(ADDR_GLOBAL);
    chk("glb_m", 16'h0000, 16'({d[2], d[0]}));
    chk("intel_m", 16'h0000, 16'(intel));
    wr(5'h00, 16'h0001);
    @(posedge clk);
    rst_pin <= 1'b0;
    ws(10);
    chk("pin_rst_m", 16'h0001, 16'(irst));
    chk("term_m", 16'h000F, 16'(lo.term_ready_out_n));
    @(posedge clk);
    rst_pin <= 1'b1;
    ws(12);
    chk("rst_end_m", 16'h0000, 16'(irst));
    tdone("motorola_reset");
    tally_and_finish();
  end
endmodule : qupcr_top_tb
